// [include/scr_pkg.sv]
// package of register map, field layout and reset values for the serdes pcs control bank
// Overview of operation
// - While digital control bit 14 is set and bit 11 is clear, received serial code groups are looped back out of the transmitter.
// - While digital control bit 11 is set, serial receiver and transmitter are off but the serial PLL stays on.
// - Writes to the negotiation control register are held until the advertisement register is next written.
// - Control bit 3 selects the role, 0 for MAC-side (slave) and 1 for PHY-side (master).
// - Control bits 2:1 select negotiation flavour, 00 SerDes and 10 SGMII, 01 and 11 reserved, reset 10.
// - Control bit 0 allows the negotiation-complete interrupt output; when 0 the output stays inactive.
// - The completion flag is set when negotiation finishes, cleared only by writing 0, and ignores the enable.
`default_nettype none
package scr_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  localparam logic [20:0] OFS_DIGITAL_CTRL = 21'h1F8000;
  localparam logic [20:0] OFS_ANEG_CTRL = 21'h1F8001;
  localparam logic [20:0] OFS_ANEG_STATUS = 21'h1F8002;
  localparam logic [20:0] OFS_ANEG_ADVERT = 21'h1F0004;
  localparam logic [20:0] OFS_EVT_STATUS = 21'h1F8010;
  localparam logic [20:0] OFS_EVT_MASK = 21'h1F8011;

  // digital control fields
  localparam int DC_LOOPBACK_BIT = 14;
  localparam int DC_POWER_SAVE_BIT = 11;
  localparam logic [15:0] DC_RESET = 16'h2400;

  // negotiation control fields
  localparam int AC_LINK_CFG_BIT = 4;
  localparam int AC_ROLE_BIT = 3;
  localparam int AC_MODE_LSB = 1;
  localparam int AC_IRQ_EN_BIT = 0;
  localparam logic [4:0] AC_RW_MASK = 5'h1F;
  localparam logic [4:0] AC_RESET = 5'h04;

  // negotiation status fields
  localparam int AS_LINK_BIT = 4;
  localparam int AS_SPEED_LSB = 2;
  localparam int AS_DUPLEX_BIT = 1;
  localparam int AS_DONE_BIT = 0;

  typedef enum logic [1:0] {
    SCR_FLAVOUR_SERDES = 2'h0,
    SCR_FLAVOUR_RSVD1 = 2'h1,
    SCR_FLAVOUR_SGMII = 2'h2,
    SCR_FLAVOUR_RSVD3 = 2'h3
  } scr_flavour_t;

  // own event bank: bit positions
  localparam int EVT_W = 3;
  localparam int EV_ANEG_DONE = 0;
  localparam int EV_LINK_CHANGE = 1;
  localparam int EV_CFG_COMMIT = 2;
  localparam logic [2:0] EVT_MASK_RESET = 3'h0;
endpackage
`default_nettype wire

// [design/scr_event_bank.sv]
// sticky event bits with write-one-to-clear, mask and one level interrupt
`default_nettype none
module scr_event_bank #(
  parameter int WIDTH = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] evtPulse,
  input wire logic clrStb,
  input wire logic [WIDTH-1:0] clrBits,
  input wire logic maskStb,
  input wire logic [WIDTH-1:0] maskBits,
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);
  logic [WIDTH-1:0] status_r;
  logic [WIDTH-1:0] status_nxt;
  logic [WIDTH-1:0] mask_r;
  logic [WIDTH-1:0] mask_nxt;
  logic irq_r;
  logic irq_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : gBit
      // a new event beats a clear in the same cycle
      always_comb begin
        status_nxt[gi] = evtPulse[gi] | (status_r[gi] & ~(clrStb & clrBits[gi]));
      end
    end
  endgenerate

  always_comb begin
    mask_nxt = maskStb ? maskBits : mask_r;
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign status = status_r;
  assign mask = mask_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// [design/scr_serdes_pcs_ctrl.sv]
// control register bank and serial-side steering for the serdes pcs port
`default_nettype none
module scr_serdes_pcs_ctrl
  import scr_pkg::*;
#(
  parameter int CODE_W = 10
) (
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [DATA_W-1:0] rdData,
  // status from the pcs negotiation logic
  input wire logic anegDone,
  input wire logic linkUp,
  input wire logic [1:0] linkSpeed,
  input wire logic fullDuplex,
  // serial code groups
  input wire logic [CODE_W-1:0] rxCode,
  input wire logic [CODE_W-1:0] pcsTxCode,
  output logic [CODE_W-1:0] txCode,
  // controls toward the pcs and the analog front end
  output logic rxEnable,
  output logic txEnable,
  output logic pllEnable,
  output logic loopbackActive,
  output logic [1:0] negotiationFlavourSelect,
  output logic roleMaster,
  output logic linkCfg,
  output logic anegIrq,
  output logic irq
);
  // decode
  logic hitDig;
  logic hitCtl;
  logic hitSts;
  logic hitAdv;
  logic hitEvt;
  logic hitMsk;

  always_comb begin
    hitDig = (addr == OFS_DIGITAL_CTRL);
    hitCtl = (addr == OFS_ANEG_CTRL);
    hitSts = (addr == OFS_ANEG_STATUS);
    hitAdv = (addr == OFS_ANEG_ADVERT);
    hitEvt = (addr == OFS_EVT_STATUS);
    hitMsk = (addr == OFS_EVT_MASK);
  end

  // digital control register, all bits read/write
  logic [15:0] digCtrl_r;
  logic [15:0] digCtrl_nxt;

  always_comb begin
    digCtrl_nxt = (wrStb && hitDig) ? wrData : digCtrl_r;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      digCtrl_r <= DC_RESET;
    end else begin
      digCtrl_r <= digCtrl_nxt;
    end
  end

  // negotiation control: a staged copy that software sees, and the applied copy
  logic [4:0] ctlStage_r;
  logic [4:0] ctlStage_nxt;
  logic [4:0] ctlLive_r;
  logic [4:0] ctlLive_nxt;
  logic commit;

  always_comb begin
    commit = wrStb && hitAdv;
    ctlStage_nxt = ctlStage_r;
    if (wrStb && hitCtl) begin
      ctlStage_nxt = wrData[4:0] & AC_RW_MASK;
    end
    ctlLive_nxt = ctlLive_r;
    if (commit) begin
      ctlLive_nxt = ctlStage_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctlStage_r <= AC_RESET;
      ctlLive_r <= AC_RESET;
    end else begin
      ctlStage_r <= ctlStage_nxt;
      ctlLive_r <= ctlLive_nxt;
    end
  end

  // completion flag: set by hardware, cleared only by a written 0
  logic doneFlag_r;
  logic doneFlag_nxt;
  logic linkUpPrev_r;
  logic linkUpPrev_nxt;

  always_comb begin
    if (anegDone) begin
      doneFlag_nxt = 1'b1;
    end else if (wrStb && hitSts && !wrData[AS_DONE_BIT]) begin
      doneFlag_nxt = 1'b0;
    end else begin
      doneFlag_nxt = doneFlag_r;
    end
    linkUpPrev_nxt = linkUp;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      doneFlag_r <= 1'b0;
      linkUpPrev_r <= 1'b0;
    end else begin
      doneFlag_r <= doneFlag_nxt;
      linkUpPrev_r <= linkUpPrev_nxt;
    end
  end

  // own event bank
  logic [EVT_W-1:0] evtPulse;
  logic [EVT_W-1:0] evtStatus;
  logic [EVT_W-1:0] evtMask;
  logic evtIrq;

  always_comb begin
    evtPulse = '0;
    evtPulse[EV_ANEG_DONE] = anegDone;
    evtPulse[EV_LINK_CHANGE] = linkUp ^ linkUpPrev_r;
    evtPulse[EV_CFG_COMMIT] = commit;
  end

  scr_event_bank #(
    .WIDTH(EVT_W)
  ) uEvents (
    .clock(clock),
    .rst(rst),
    .evtPulse(evtPulse),
    .clrStb(wrStb && hitEvt),
    .clrBits(wrData[EVT_W-1:0]),
    .maskStb(wrStb && hitMsk),
    .maskBits(wrData[EVT_W-1:0]),
    .status(evtStatus),
    .mask(evtMask),
    .irq(evtIrq)
  );

  // read path, data valid the cycle after the strobe only
  logic [15:0] rdData_r;
  logic [15:0] rdData_nxt;
  logic [15:0] stsWord;

  always_comb begin
    stsWord = '0;
    stsWord[AS_LINK_BIT] = linkUp;
    stsWord[AS_SPEED_LSB +: 2] = linkSpeed;
    stsWord[AS_DUPLEX_BIT] = fullDuplex;
    stsWord[AS_DONE_BIT] = doneFlag_r;
    rdData_nxt = 16'h0000;
    if (rdStb) begin
      if (hitDig) begin
        rdData_nxt = digCtrl_r;
      end else if (hitCtl) begin
        rdData_nxt = {11'h000, ctlStage_r};
      end else if (hitSts) begin
        rdData_nxt = stsWord;
      end else if (hitEvt) begin
        rdData_nxt = {13'h0000, evtStatus};
      end else if (hitMsk) begin
        rdData_nxt = {13'h0000, evtMask};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData_r <= 16'h0000;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  // front end steering and serial data path
  logic loop_nxt;
  logic save_nxt;
  logic [CODE_W-1:0] txCode_r;
  logic [CODE_W-1:0] txCode_nxt;
  logic rxEnable_r;
  logic txEnable_r;
  logic loop_r;
  logic anegIrq_r;
  logic anegIrq_nxt;

  always_comb begin
    loop_nxt = digCtrl_nxt[DC_LOOPBACK_BIT];
    save_nxt = digCtrl_nxt[DC_POWER_SAVE_BIT];
    if (digCtrl_r[DC_POWER_SAVE_BIT]) begin
      // a powered-down transmitter sends nothing, loopback or not
      txCode_nxt = '0;
    end else if (digCtrl_r[DC_LOOPBACK_BIT]) begin
      txCode_nxt = rxCode;
    end else begin
      txCode_nxt = pcsTxCode;
    end
    anegIrq_nxt = doneFlag_nxt & ctlLive_nxt[AC_IRQ_EN_BIT];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txCode_r <= '0;
      rxEnable_r <= 1'b1;
      txEnable_r <= 1'b1;
      loop_r <= 1'b0;
      anegIrq_r <= 1'b0;
    end else begin
      txCode_r <= txCode_nxt;
      rxEnable_r <= !save_nxt;
      txEnable_r <= !save_nxt;
      loop_r <= loop_nxt;
      anegIrq_r <= anegIrq_nxt;
    end
  end

  // pll stays on in every mode; the register only keeps the output registered
  logic pll_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pll_r <= 1'b1;
    end else begin
      pll_r <= 1'b1;
    end
  end

  assign rdData = rdData_r;
  assign txCode = txCode_r;
  assign rxEnable = rxEnable_r;
  assign txEnable = txEnable_r;
  assign pllEnable = pll_r;
  assign loopbackActive = loop_r;
  assign negotiationFlavourSelect = ctlLive_r[AC_MODE_LSB +: 2];
  assign roleMaster = ctlLive_r[AC_ROLE_BIT];
  assign linkCfg = ctlLive_r[AC_LINK_CFG_BIT];
  assign anegIrq = anegIrq_r;
  assign irq = evtIrq;
endmodule
`default_nettype wire

// [tb/scr_link_model.sv]
// far-side stand-in: negotiation results and serial code groups
`default_nettype none
module scr_link_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic finish,
  output logic anegDone,
  output logic linkUp,
  output logic [1:0] linkSpeed,
  output logic fullDuplex,
  output logic [9:0] rxCode,
  output logic [9:0] pcsTxCode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic finishD;
  // speed and duplex settle the cycle after the completion pulse
  assign linkSpeed = linkUp ? 2'h2 : 2'h0;
  assign fullDuplex = linkUp;
  // codes move every cycle so a stale copy never matches
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      finishD <= 1'b0;
      anegDone <= 1'b0;
      linkUp <= 1'b0;
      rxCode <= 10'h0;
      pcsTxCode <= 10'h0;
    end else begin
      finishD <= finish;
      anegDone <= finish ^ finishD;
      linkUp <= linkUp | anegDone;
      rxCode <= rxCode + 10'h1;
      pcsTxCode <= rxCode ^ 10'h2AA;
    end
  end
endmodule
`default_nettype wire

// [tb/scr_serdes_pcs_ctrl_monitor.sv]
// port relation checker for the serdes pcs control bank
`default_nettype none
module scr_serdes_pcs_ctrl_monitor
  import scr_pkg::*;
#(
  parameter int CODE_W = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic wrStb,
  input wire logic anegDone,
  input wire logic [CODE_W-1:0] rxCode,
  input wire logic [CODE_W-1:0] pcsTxCode,
  input wire logic [CODE_W-1:0] txCode,
  input wire logic rxEnable,
  input wire logic txEnable,
  input wire logic pllEnable,
  input wire logic loopbackActive,
  input wire logic [1:0] negotiationFlavourSelect,
  input wire logic roleMaster,
  input wire logic linkCfg,
  input wire logic anegIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  logic wrCtl, wrAdv;
  logic [3:0] ctl;
  assign wrCtl = wrStb && addr == OFS_ANEG_CTRL;
  assign wrAdv = wrStb && addr == OFS_ANEG_ADVERT;
  assign ctl = {linkCfg, roleMaster, negotiationFlavourSelect};
  property p_pll;
    pllEnable && rxEnable == txEnable;
  endproperty
  property p_save;
    !$past(rst) && !$past(rxEnable) |-> txCode == '0;
  endproperty
  property p_loop;
    !$past(rst) && $past(loopbackActive) && $past(rxEnable) |-> txCode == $past(rxCode);
  endproperty
  property p_norm;
    !$past(rst) && !$past(loopbackActive) && $past(rxEnable) |-> txCode == $past(pcsTxCode);
  endproperty
  // staged writes leave the applied outputs alone
  property p_hold;
    wrCtl |=> $stable(ctl) ##1 ($past(wrAdv) || $stable(ctl));
  endproperty
  property p_commit;
    $changed(ctl) |-> $past(wrAdv) || $past(wrAdv, 2);
  endproperty
  property p_irqUp;
    $rose(anegIrq) |-> $past(anegDone) || $past(wrAdv) || $past(wrAdv, 2);
  endproperty
  property p_irqDown;
    $fell(anegIrq) |-> $past(wrStb) || $past(wrStb, 2);
  endproperty
  a_pll: assert property (p_pll) else $error("pll or enables wrong");
  a_save: assert property (p_save) else $error("tx code not quiet");
  a_loop: assert property (p_loop) else $error("loopback code wrong");
  a_norm: assert property (p_norm) else $error("normal code wrong");
  a_hold: assert property (p_hold) else $error("staged write applied");
  a_commit: assert property (p_commit) else $error("control moved alone");
  a_irqUp: assert property (p_irqUp) else $error("irq rose alone");
  a_irqDown: assert property (p_irqDown) else $error("irq fell alone");
  c_loop: cover property (loopbackActive && rxEnable);
  c_irq: cover property ($rose(anegIrq));
  c_save: cover property (!rxEnable);
endmodule
bind scr_serdes_pcs_ctrl scr_serdes_pcs_ctrl_monitor #(.CODE_W(CODE_W)) mon_i (.clock, .rst,
  .addr, .wrStb, .anegDone, .rxCode, .pcsTxCode, .txCode, .rxEnable, .txEnable, .pllEnable,
  .loopbackActive, .negotiationFlavourSelect, .roleMaster, .linkCfg, .anegIrq);
`default_nettype wire

// [tb/scr_serdes_pcs_ctrl_tb.sv]
// self-checking bench for the serdes pcs control bank
`default_nettype none
module scr_serdes_pcs_ctrl_tb
  import scr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, wrStb = 0, rdStb = 0, finish = 0;
  logic [20:0] addr = '0;
  logic [15:0] wrData = '0, rdData;
  logic anegDone, linkUp, fullDuplex, rxEnable, txEnable, pllEnable, loopbackActive;
  logic roleMaster, linkCfg, anegIrq, irq;
  logic [1:0] linkSpeed, negotiationFlavourSelect;
  logic [9:0] rxCode, pcsTxCode, txCode;
  int fails = 0, nChecks = 0, cyc = 0;
  scr_link_model scr_link_model_i (.clock, .rst, .finish, .anegDone, .linkUp, .linkSpeed,
    .fullDuplex, .rxCode, .pcsTxCode);
  scr_serdes_pcs_ctrl scr_serdes_pcs_ctrl_i (.clock, .rst, .addr, .wrData, .wrStb, .rdStb,
    .rdData, .anegDone, .linkUp, .linkSpeed, .fullDuplex, .rxCode, .pcsTxCode, .txCode,
    .rxEnable, .txEnable, .pllEnable, .loopbackActive, .negotiationFlavourSelect,
    .roleMaster, .linkCfg, .anegIrq, .irq);
  wire [15:0] ctl = {12'h0, linkCfg, roleMaster, negotiationFlavourSelect};
  wire [15:0] fe = {12'h0, rxEnable, txEnable, pllEnable, loopbackActive};
  wire [15:0] ir = {14'h0, anegIrq, irq};
  always #2 clock = ~clock;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // a hung handshake must still reach the verdict
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    nChecks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [20:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clock);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [20:0] a, input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1 chk("rdData", e, rdData);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic done();
    @(posedge clock);
    finish <= ~finish;
    tick(4);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(OFS_DIGITAL_CTRL, DC_RESET);
    rd(OFS_ANEG_CTRL, {11'h0, AC_RESET});
    rd(21'h000123, 16'h0000);
    chk("ctl", 16'h0002, ctl);
    chk("fe", 16'h000E, fe);
    $display("test reset done");
    // serdes flavour with role set
    wr(OFS_ANEG_CTRL, 16'hFFF9);
    rd(OFS_ANEG_CTRL, 16'h0019);
    tick(2);
    chk("ctl", 16'h0002, ctl);
    wr(OFS_ANEG_ADVERT, 16'h0000);
    tick(2);
    chk("ctl", 16'h000C, ctl & 16'h000F);
    $display("test staging done");
    done();
    chk("irq", 16'h0002, ir);
    rd(OFS_ANEG_STATUS, 16'h001B);
    wr(OFS_ANEG_STATUS, 16'h0001);
    tick(2);
    chk("irq", 16'h0002, ir);
    wr(OFS_ANEG_STATUS, 16'h0000);
    tick(2);
    chk("irq", 16'h0000, ir);
    // sgmii flavour, mac side, enable off
    wr(OFS_ANEG_CTRL, 16'h0004);
    wr(OFS_ANEG_ADVERT, 16'h0000);
    done();
    chk("irq", 16'h0000, ir);
    rd(OFS_ANEG_STATUS, 16'h001B);
    wr(OFS_ANEG_CTRL, 16'h0005);
    wr(OFS_ANEG_ADVERT, 16'h0000);
    tick(2);
    chk("irq", 16'h0002, ir);
    chk("ctl", 16'h0002, ctl);
    $display("test completion done");
    rd(OFS_EVT_STATUS, 16'h0007);
    wr(OFS_EVT_MASK, 16'h0004);
    rd(OFS_EVT_MASK, 16'h0004);
    wr(OFS_EVT_STATUS, 16'h0003);
    tick(2);
    chk("irq", 16'h0003, ir);
    wr(OFS_EVT_STATUS, 16'h0004);
    rd(OFS_EVT_STATUS, 16'h0000);
    chk("irq", 16'h0002, ir);
    $display("test events done");
    wr(OFS_DIGITAL_CTRL, 16'h6400);
    tick(3);
    chk("fe", 16'h000F, fe);
    // the far side steps its received code by one each cycle
    chk("txCode", {6'h0, rxCode - 10'h1}, {6'h0, txCode});
    wr(OFS_DIGITAL_CTRL, 16'h6C00);
    tick(3);
    chk("fe", 16'h0003, fe);
    chk("txCode", 16'h0000, {6'h0, txCode});
    rd(OFS_DIGITAL_CTRL, 16'h6C00);
    wr(OFS_DIGITAL_CTRL, DC_RESET);
    tick(3);
    chk("fe", 16'h000E, fe);
    chk("txCode", {6'h0, (rxCode - 10'h2) ^ 10'h2AA}, {6'h0, txCode});
    $display("test front end done");
    wrap_up();
  end
endmodule
`default_nettype wire
